// >>> rtl/mpq_pkg.sv
package mpq_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 6;

  // register word addresses
  localparam logic [5:0] ADR_RUN      = 6'h00;
  localparam logic [5:0] ADR_CH3_CTRL = 6'h01;
  localparam logic [5:0] ADR_CH3_MODE = 6'h02;
  localparam logic [5:0] ADR_OUT_CTRL = 6'h03;
  localparam logic [5:0] ADR_BUS_CTRL = 6'h04;
  localparam logic [5:0] ADR_CH3_CNT  = 6'h05;
  localparam logic [5:0] ADR_CH4_CNT  = 6'h06;
  localparam logic [5:0] ADR_PERIOD   = 6'h07;
  localparam logic [5:0] ADR_PH1_CMP  = 6'h08;
  localparam logic [5:0] ADR_PER_BUF  = 6'h09;
  localparam logic [5:0] ADR_PH1_BUF  = 6'h0a;
  localparam logic [5:0] ADR_PH2_CMP  = 6'h0b;
  localparam logic [5:0] ADR_PH3_CMP  = 6'h0c;
  localparam logic [5:0] ADR_PH2_BUF  = 6'h0d;
  localparam logic [5:0] ADR_PH3_BUF  = 6'h0e;
  localparam logic [5:0] ADR_DEADTIME = 6'h0f;
  localparam logic [5:0] ADR_CYC_DATA = 6'h10;
  localparam logic [5:0] ADR_CYC_BUF  = 6'h11;
  localparam logic [5:0] ADR_SUBCNT   = 6'h12;
  localparam logic [5:0] ADR_CH1_CNT  = 6'h13;
  localparam logic [5:0] ADR_CH1_CAPA = 6'h14;
  localparam logic [5:0] ADR_CH1_CAPB = 6'h15;
  localparam logic [5:0] ADR_CH1_MODE = 6'h16;
  localparam logic [5:0] ADR_CH0_CNT  = 6'h17;
  localparam logic [5:0] ADR_CH0_SPD  = 6'h18;
  localparam logic [5:0] ADR_CH0_POS  = 6'h19;
  localparam logic [5:0] ADR_CH0_CAP  = 6'h1a;
  localparam logic [5:0] ADR_CH0_CBUF = 6'h1b;
  localparam logic [5:0] ADR_CH0_CTRL = 6'h1c;

  // run bits
  localparam int unsigned RUN_CH0 = 0;
  localparam int unsigned RUN_CH1 = 1;
  localparam int unsigned RUN_CH3 = 6;
  localparam int unsigned RUN_CH4 = 7;
  // ch3 control fields
  localparam int unsigned PSC_LSB = 0;
  localparam int unsigned EDGE_LSB = 3;
  localparam int unsigned CLR_LSB = 5;
  localparam logic [2:0] CLR_PERIOD = 3'h1;
  // output control bits
  localparam int unsigned OC_NEG_LVL = 0;
  localparam int unsigned OC_POS_LVL = 1;
  localparam int unsigned OC_SYNC_EN = 6;
  // bus control access bit
  localparam int unsigned BC_ACCESS = 13;
  // mode field codes
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_PHASE4 = 4'h7;
  localparam logic [3:0] MODE_RSYNC  = 4'h8;
  localparam logic [3:0] MODE_COMP_LO = 4'hd;
  localparam logic [3:0] MODE_COMP_HI = 4'hf;
  // ch0 control: capture source select bit
  localparam int unsigned C0_CAP_ENC = 0;

  localparam logic [15:0] RST_BUS_CTRL = 16'h2000;
  localparam logic [15:0] RST_PERIOD   = 16'hffff;
endpackage

// >>> rtl/mpq_quad_dec.sv
`timescale 1ns/1ps
module mpq_quad_dec
(
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic phase_a_i,
  input  wire logic phase_b_i,
  output logic      up_o,
  output logic      down_o
);
  logic [1:0] a_sync_q;
  logic [1:0] b_sync_q;
  logic       a_q;
  logic       b_q;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      a_sync_q <= 2'h0;
      b_sync_q <= 2'h0;
      a_q      <= 1'b0;
      b_q      <= 1'b0;
    end
    else
    begin
      a_sync_q <= {a_sync_q[0], phase_a_i};
      b_sync_q <= {b_sync_q[0], phase_b_i};
      a_q      <= a_sync_q[1];
      b_q      <= b_sync_q[1];
    end
  end

  always_comb
  begin
    up_o   = (b_sync_q[1] & ~b_q & a_q) | (~b_sync_q[1] & b_q & ~a_q);
    down_o = (~b_sync_q[1] & b_q & a_q) | (b_sync_q[1] & ~b_q & ~a_q);
  end
endmodule

// >>> rtl/mpq_timer.sv
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
module mpq_timer
(
  input  wire logic                          clk_i,
  input  wire logic                          sys_rst_i,
  input  wire logic [mpq_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic [mpq_pkg::DATA_W-1:0]    wdata_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  output logic      [mpq_pkg::DATA_W-1:0]    rdata_o,
  input  wire logic                          enc_phase_a_ch1_i,
  input  wire logic                          enc_phase_b_ch1_i,
  output logic                               ch3_pin_a_sync_toggle_o,
  output logic                               pwm_phase1_pos_o,
  output logic                               pwm_phase1_neg_o,
  output logic                               pwm_phase2_pos_o,
  output logic                               pwm_phase2_neg_o,
  output logic                               pwm_phase3_pos_o,
  output logic                               pwm_phase3_neg_o,
  output logic                               pwm_pins_en_o
);
  import mpq_pkg::*;

  logic [7:0]  run_q;
  logic [7:0]  ch3_ctrl_q;
  logic [3:0]  ch3_mode_q;
  logic [3:0]  ch1_mode_q;
  logic [7:0]  out_ctrl_q;
  logic [15:0] bus_ctrl_q;
  logic [15:0] ch0_ctrl_q;
  logic [15:0] ch3_cnt_q;
  logic [15:0] ch4_cnt_q;
  logic [15:0] sub_cnt_q;
  logic [15:0] ch1_cnt_q;
  logic [15:0] ch0_cnt_q;
  logic [15:0] cmp_q [0:4];
  logic [15:0] buf_q [0:4];
  logic [15:0] temp_q [0:2];
  logic [15:0] deadtime_q;
  logic [15:0] ch1_cap_a_q;
  logic [15:0] ch1_cap_b_q;
  logic [15:0] ch0_spd_q;
  logic [15:0] ch0_pos_q;
  logic [15:0] ch0_cap_q;
  logic [15:0] ch0_cbuf_q;
  logic [15:0] ch0_width_q;
  logic        ch3_dir_dn_q;
  logic        ch4_dir_dn_q;
  logic [2:0]  phase_q;
  logic        sync_tgl_q;
  logic [7:0]  psc_q;
  logic        enc_up;
  logic        enc_dn;
  logic        tick;
  logic        rsync;
  logic        comp;
  logic        access_ok;
  logic        ch3_match_period;
  logic [2:0]  ph_match;
  logic [15:0] rd_val;

  // index into cmp_q/buf_q: 0 period, 1..3 phases, 4 cycle data
  localparam int unsigned IX_PER = 0;
  localparam int unsigned IX_CYC = 4;

  mpq_quad_dec u_dec
  (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .phase_a_i (enc_phase_a_ch1_i),
    .phase_b_i (enc_phase_b_ch1_i),
    .up_o      (enc_up),
    .down_o    (enc_dn)
  );

  function automatic logic is_comp(input logic [3:0] m);
    is_comp = (m >= MODE_COMP_LO) && (m <= MODE_COMP_HI);
  endfunction

  assign rsync = (ch3_mode_q == MODE_RSYNC);
  assign comp  = is_comp(ch3_mode_q);
  assign access_ok = bus_ctrl_q[BC_ACCESS];

  // prescaler: 1, 4, 16, 256 selected by low bits
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      psc_q <= 8'h00;
    else
      psc_q <= psc_q + 8'h01;
  end
  always_comb
  begin
    case (ch3_ctrl_q[PSC_LSB +: 2])
      2'h0:    tick = 1'b1;
      2'h1:    tick = (psc_q[1:0] == 2'h3);
      2'h2:    tick = (psc_q[3:0] == 4'hf);
      default: tick = (psc_q == 8'hff);
    endcase
  end

  assign ch3_match_period = (ch3_cnt_q == cmp_q[IX_PER]);
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      ph_match[i] = (ch3_cnt_q == cmp_q[i+1]);
  end

  // register writes
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      run_q      <= 8'h00;
      ch3_ctrl_q <= 8'h00;
      ch3_mode_q <= MODE_NORMAL;
      ch1_mode_q <= MODE_NORMAL;
      out_ctrl_q <= 8'h00;
      bus_ctrl_q <= RST_BUS_CTRL;
      ch0_ctrl_q <= 16'h0000;
      deadtime_q <= 16'h0000;
      ch0_spd_q  <= RST_PERIOD;
      ch0_pos_q  <= RST_PERIOD;
      for (int i = 0; i < 5; i++)
        buf_q[i] <= RST_PERIOD;
    end
    else if (wr_i)
    begin
      case (addr_i)
        ADR_RUN:      run_q <= wdata_i[7:0];
        ADR_CH3_CTRL: ch3_ctrl_q <= wdata_i[7:0];
        ADR_CH3_MODE: ch3_mode_q <= wdata_i[3:0];
        ADR_CH1_MODE: ch1_mode_q <= wdata_i[3:0];
        ADR_OUT_CTRL: out_ctrl_q <= wdata_i[7:0];
        ADR_BUS_CTRL: bus_ctrl_q <= wdata_i;
        ADR_CH0_CTRL: ch0_ctrl_q <= wdata_i;
        ADR_CH0_SPD:  ch0_spd_q <= wdata_i;
        ADR_CH0_POS:  ch0_pos_q <= wdata_i;
        ADR_PER_BUF:  buf_q[0] <= wdata_i;
        ADR_PH1_BUF:  buf_q[1] <= wdata_i;
        ADR_PH2_BUF:  buf_q[2] <= wdata_i;
        ADR_PH3_BUF:  buf_q[3] <= wdata_i;
        ADR_CYC_BUF:  buf_q[4] <= wdata_i;
        ADR_DEADTIME: if (access_ok) deadtime_q <= wdata_i;
        default: ;
      endcase
    end
  end

  // compare registers and hidden temporaries
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < 5; i++)
        cmp_q[i] <= RST_PERIOD;
      for (int i = 0; i < 3; i++)
        temp_q[i] <= 16'h0000;
    end
    else if (wr_i && access_ok && addr_i == ADR_PERIOD)
      cmp_q[0] <= wdata_i;
    else if (wr_i && access_ok && addr_i == ADR_PH1_CMP)
      cmp_q[1] <= wdata_i;
    else if (wr_i && access_ok && addr_i == ADR_PH2_CMP)
      cmp_q[2] <= wdata_i;
    else if (wr_i && access_ok && addr_i == ADR_PH3_CMP)
      cmp_q[3] <= wdata_i;
    else if (wr_i && access_ok && addr_i == ADR_CYC_DATA)
      cmp_q[4] <= wdata_i;
    // temporaries follow buffers, no cpu path
    else if (comp && ~run_q[RUN_CH3])
    begin
      for (int i = 0; i < 5; i++)
        cmp_q[i] <= buf_q[i];
      for (int i = 0; i < 3; i++)
        temp_q[i] <= buf_q[i+1];
    end
    else if (comp && tick && ch4_cnt_q == 16'h0000 && ch4_dir_dn_q)
    begin
      for (int i = 0; i < 3; i++)
      begin
        temp_q[i]  <= buf_q[i+1];
        cmp_q[i+1] <= temp_q[i];
      end
    end
  end

  // channel 3 and 4 counters
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ch3_cnt_q    <= 16'h0000;
      ch4_cnt_q    <= 16'h0000;
      ch3_dir_dn_q <= 1'b0;
      ch4_dir_dn_q <= 1'b0;
    end
    else if (wr_i && access_ok && addr_i == ADR_CH3_CNT)
      ch3_cnt_q <= wdata_i;
    else if (wr_i && access_ok && addr_i == ADR_CH4_CNT)
      ch4_cnt_q <= wdata_i;
    // halted complementary ch3 rests at dead time
    else if (comp && ~run_q[RUN_CH3])
    begin
      ch3_cnt_q    <= deadtime_q;
      ch3_dir_dn_q <= 1'b0;
      ch4_dir_dn_q <= 1'b0;
    end
    else if (tick && run_q[RUN_CH3])
    begin
      if (comp)
      begin
        ch3_cnt_q <= ch3_dir_dn_q ? ch3_cnt_q - 16'h0001 : ch3_cnt_q + 16'h0001;
        if (!ch3_dir_dn_q && ch3_cnt_q + 16'h0001 == cmp_q[IX_PER])
          ch3_dir_dn_q <= 1'b1;
        else if (ch3_dir_dn_q && ch3_cnt_q - 16'h0001 == deadtime_q)
          ch3_dir_dn_q <= 1'b0;
        // ch4 reverses at cycle data and zero
        if (run_q[RUN_CH4])
        begin
          ch4_cnt_q <= ch4_dir_dn_q ? ch4_cnt_q - 16'h0001 : ch4_cnt_q + 16'h0001;
          if (!ch4_dir_dn_q && ch4_cnt_q + 16'h0001 == cmp_q[IX_CYC])
            ch4_dir_dn_q <= 1'b1;
          else if (ch4_dir_dn_q && ch4_cnt_q == 16'h0001)
            ch4_dir_dn_q <= 1'b0;
        end
      end
      else if (rsync && ch3_ctrl_q[CLR_LSB +: 3] == CLR_PERIOD && ch3_match_period)
      begin
        ch3_cnt_q <= 16'h0000;
        ch4_cnt_q <= 16'h0000;
      end
      else
      begin
        ch3_cnt_q <= ch3_cnt_q + 16'h0001;
        if (rsync)
          ch4_cnt_q <= ch4_cnt_q + 16'h0001;
      end
    end
  end

  // subcounter tracks ch3 offset by dead time
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      sub_cnt_q <= 16'h0000;
    else if (comp && run_q[RUN_CH3] && tick)
      sub_cnt_q <= ch3_cnt_q - deadtime_q;
  end

  // phase outputs
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      phase_q    <= 3'h0;
      sync_tgl_q <= 1'b0;
    end
    else if (tick && run_q[RUN_CH3])
    begin
      if (rsync)
      begin
        // toggle at transition match and at clear
        // equal to period toggles once there
        for (int i = 0; i < 3; i++)
          if (ph_match[i] | ch3_match_period)
            phase_q[i] <= ~phase_q[i];
        if (ch3_match_period && out_ctrl_q[OC_SYNC_EN])
          sync_tgl_q <= ~sync_tgl_q;
      end
      else if (comp)
      begin
        // set at match counting up, clear counting down
        for (int i = 0; i < 3; i++)
          if (sub_cnt_q == cmp_q[i+1])
            phase_q[i] <= ~ch3_dir_dn_q;
        if ((ch3_cnt_q == cmp_q[IX_PER] || ch3_cnt_q == deadtime_q)
            && out_ctrl_q[OC_SYNC_EN])
          sync_tgl_q <= ~sync_tgl_q;
      end
    end
  end

  // pin drivers
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pwm_phase1_pos_o        <= 1'b0;
      pwm_phase1_neg_o        <= 1'b0;
      pwm_phase2_pos_o        <= 1'b0;
      pwm_phase2_neg_o        <= 1'b0;
      pwm_phase3_pos_o        <= 1'b0;
      pwm_phase3_neg_o        <= 1'b0;
      ch3_pin_a_sync_toggle_o <= 1'b0;
      pwm_pins_en_o           <= 1'b0;
    end
    else
    begin
      // positive and inverted share transition instants
      pwm_phase1_pos_o <= phase_q[0] ^ ~out_ctrl_q[OC_POS_LVL];
      pwm_phase1_neg_o <= ~phase_q[0] ^ ~out_ctrl_q[OC_NEG_LVL];
      pwm_phase2_pos_o <= phase_q[1] ^ ~out_ctrl_q[OC_POS_LVL];
      pwm_phase2_neg_o <= ~phase_q[1] ^ ~out_ctrl_q[OC_NEG_LVL];
      pwm_phase3_pos_o <= phase_q[2] ^ ~out_ctrl_q[OC_POS_LVL];
      pwm_phase3_neg_o <= ~phase_q[2] ^ ~out_ctrl_q[OC_NEG_LVL];
      ch3_pin_a_sync_toggle_o <= sync_tgl_q;
      pwm_pins_en_o <= rsync | comp;
    end
  end

  // channel 1 encoder counter and captures, channel 0
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ch1_cnt_q   <= 16'h0000;
      ch1_cap_a_q <= 16'h0000;
      ch1_cap_b_q <= 16'h0000;
      ch0_cnt_q   <= 16'h0000;
      ch0_cap_q   <= 16'h0000;
      ch0_cbuf_q  <= 16'h0000;
      ch0_width_q <= 16'h0000;
    end
    else
    begin
      if (wr_i && access_ok && addr_i == ADR_CH1_CNT)
        ch1_cnt_q <= wdata_i;
      else if (run_q[RUN_CH1] && ch1_mode_q == MODE_PHASE4)
      begin
        if (enc_up)
          ch1_cnt_q <= ch1_cnt_q + 16'h0001;
        else if (enc_dn)
          ch1_cnt_q <= ch1_cnt_q - 16'h0001;
      end
      if (run_q[RUN_CH0])
      begin
        ch0_cnt_q   <= (ch0_cnt_q == ch0_pos_q) ? 16'h0000 : ch0_cnt_q + 16'h0001;
        ch0_width_q <= ch0_width_q + 16'h0001;
        if (ch0_cnt_q == ch0_spd_q)
          ch1_cap_a_q <= ch1_cnt_q;
        if (ch0_cnt_q == ch0_pos_q)
          ch1_cap_b_q <= ch1_cnt_q;
        // ch1 count clock captures ch0 width
        if (ch0_ctrl_q[C0_CAP_ENC] && (enc_up | enc_dn))
        begin
          ch0_cap_q   <= ch0_width_q;
          ch0_cbuf_q  <= ch0_cap_q;
          // width counts the capture cycle itself
          ch0_width_q <= 16'h0001;
        end
      end
      if (wr_i && access_ok && addr_i == ADR_CH0_CNT)
        ch0_cnt_q <= wdata_i;
    end
  end

  // read mux; gated registers other than ch0 count read zero when access disabled
  always_comb
  begin
    rd_val = 16'h0000;
    case (addr_i)
      ADR_RUN:      rd_val = {8'h00, run_q};
      ADR_CH3_CTRL: rd_val = {8'h00, ch3_ctrl_q};
      ADR_CH3_MODE: rd_val = {12'h000, ch3_mode_q};
      ADR_CH1_MODE: rd_val = {12'h000, ch1_mode_q};
      ADR_OUT_CTRL: rd_val = {8'h00, out_ctrl_q};
      ADR_BUS_CTRL: rd_val = bus_ctrl_q;
      ADR_CH0_CTRL: rd_val = ch0_ctrl_q;
      ADR_PER_BUF:  rd_val = buf_q[0];
      ADR_PH1_BUF:  rd_val = buf_q[1];
      ADR_PH2_BUF:  rd_val = buf_q[2];
      ADR_PH3_BUF:  rd_val = buf_q[3];
      ADR_CYC_BUF:  rd_val = buf_q[4];
      ADR_SUBCNT:   rd_val = sub_cnt_q;
      ADR_CH0_CNT:  rd_val = ch0_cnt_q;
      ADR_CH0_SPD:  rd_val = ch0_spd_q;
      ADR_CH0_POS:  rd_val = ch0_pos_q;
      ADR_CH0_CAP:  rd_val = ch0_cap_q;
      ADR_CH0_CBUF: rd_val = ch0_cbuf_q;
      ADR_CH1_CAPA: rd_val = ch1_cap_a_q;
      ADR_CH1_CAPB: rd_val = ch1_cap_b_q;
      ADR_CH3_CNT:  rd_val = access_ok ? ch3_cnt_q : 16'h0000;
      ADR_CH4_CNT:  rd_val = access_ok ? ch4_cnt_q : 16'h0000;
      ADR_CH1_CNT:  rd_val = access_ok ? ch1_cnt_q : 16'h0000;
      ADR_PERIOD:   rd_val = access_ok ? cmp_q[0] : 16'h0000;
      ADR_PH1_CMP:  rd_val = access_ok ? cmp_q[1] : 16'h0000;
      ADR_PH2_CMP:  rd_val = access_ok ? cmp_q[2] : 16'h0000;
      ADR_PH3_CMP:  rd_val = access_ok ? cmp_q[3] : 16'h0000;
      ADR_CYC_DATA: rd_val = access_ok ? cmp_q[4] : 16'h0000;
      ADR_DEADTIME: rd_val = access_ok ? deadtime_q : 16'h0000;
      default:      rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      rdata_o <= 16'h0000;
    else if (rd_i)
      rdata_o <= rd_val;
    else
      rdata_o <= 16'h0000;
  end
endmodule

// >>> bench/mpq_timer_monitor.sv
`timescale 1ns/1ps
module mpq_timer_monitor
  import mpq_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [5:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [15:0] rdata_o,
  input  wire logic        ch3_pin_a_sync_toggle_o,
  input  wire logic        pwm_phase1_pos_o,
  input  wire logic        pwm_phase1_neg_o,
  input  wire logic        pwm_phase2_pos_o,
  input  wire logic        pwm_phase2_neg_o,
  input  wire logic        pwm_phase3_pos_o,
  input  wire logic        pwm_phase3_neg_o,
  input  wire logic        pwm_pins_en_o
);
  logic [15:0] oc_q, bc_q, buf_q, run_q;
  logic [3:0]  mode_q;
  logic        buf_ok_q;
  logic [1:0]  age_q;
  logic        rdy, rsync, lv_ok;
  logic [5:0]  pins;
  assign rdy   = age_q == 2'h3;
  assign rsync = mode_q == MODE_RSYNC;
  assign lv_ok = oc_q[OC_POS_LVL] == oc_q[OC_NEG_LVL];
  assign pins  = {pwm_phase1_pos_o, pwm_phase1_neg_o, pwm_phase2_pos_o,
                  pwm_phase2_neg_o, pwm_phase3_pos_o, pwm_phase3_neg_o};
  // shadow of software settings
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      oc_q <= 16'h0000;
      bc_q <= RST_BUS_CTRL;
      run_q <= 16'h0000;
      mode_q <= MODE_NORMAL;
      buf_q <= 16'h0000;
      buf_ok_q <= 1'b0;
    end
    else if (wr_i)
    begin
      if (addr_i == ADR_OUT_CTRL) oc_q <= wdata_i;
      if (addr_i == ADR_BUS_CTRL) bc_q <= wdata_i;
      if (addr_i == ADR_RUN) run_q <= wdata_i;
      if (addr_i == ADR_CH3_MODE) mode_q <= wdata_i[3:0];
      if (addr_i == ADR_PH1_BUF)
      begin
        buf_q <= wdata_i;
        buf_ok_q <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i) age_q <= 2'h0;
    else if (!rdy) age_q <= age_q + 2'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_rdata_quiet: assert property (rdy && !$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data outside read slot");
  chk_pair_opposite: assert property (rdy && rsync && lv_ok && $past(oc_q, 2) == oc_q
    && $past(mode_q, 2) == mode_q |-> pwm_phase1_pos_o != pwm_phase1_neg_o
    && pwm_phase2_pos_o != pwm_phase2_neg_o && pwm_phase3_pos_o != pwm_phase3_neg_o)
    else $error("phase pair not opposite");
  chk_pins_mode: assert property (rdy && $past(mode_q, 2) == mode_q |->
    pwm_pins_en_o == (rsync || (mode_q >= MODE_COMP_LO && mode_q <= MODE_COMP_HI)))
    else $error("pin enable disagrees with mode");
  chk_halt_holds: assert property (rdy && rsync && !run_q[RUN_CH3]
    && !$past(run_q[RUN_CH3], 3) && $past(oc_q, 2) == oc_q && $past(mode_q, 2) == mode_q
    |-> $stable(pins))
    else $error("output moved while halted");
  chk_edges_shared: assert property (rdy && rsync && $past(oc_q, 2) == oc_q
    && $past(mode_q, 2) == mode_q |-> $changed(pins[5]) == $changed(pins[4])
    && $changed(pins[3]) == $changed(pins[2]) && $changed(pins[1]) == $changed(pins[0]))
    else $error("pair outputs switched apart");
  chk_access_gate: assert property (rdy && rd_i && addr_i == ADR_PERIOD
    && !bc_q[BC_ACCESS] |=> rdata_o == 16'h0000)
    else $error("masked register readable");
  chk_buffer_open: assert property (rdy && rd_i && addr_i == ADR_PH1_BUF && buf_ok_q
    |=> rdata_o == buf_q)
    else $error("buffer read wrong");
  chk_sync_quiet: assert property (rdy && !oc_q[OC_SYNC_EN] && $past(oc_q, 2) == oc_q
    && $past(mode_q, 2) == mode_q |-> $stable(ch3_pin_a_sync_toggle_o))
    else $error("sync toggle while disabled");
  cover property (rdy && rsync && $changed(pwm_phase1_pos_o));
  cover property (rd_i && !bc_q[BC_ACCESS]);
  cover property (pwm_pins_en_o && mode_q == MODE_COMP_LO);
endmodule

// >>> bench/mpq_motor_model.sv
`timescale 1ns/1ps
module mpq_motor_model
(
  input  wire logic clk_i,
  input  wire logic step_i,
  input  wire logic dir_i,
  input  wire logic wob_i,
  input  wire logic clr_i,
  input  wire logic [5:0] pins_i,
  output logic      phase_a_o,
  output logic      phase_b_o,
  output int        overlap_o
);
  logic [1:0] idx_q  = 2'h0;
  logic       flip_q = 1'b0;
  // a leads b when turning forward
  always_ff @(posedge clk_i)
  begin
    if (step_i) idx_q <= dir_i ? idx_q + 2'h1 : idx_q - 2'h1;
    if (wob_i) flip_q <= ~flip_q;
  end
  assign phase_a_o = idx_q[0] ^ idx_q[1] ^ flip_q;
  assign phase_b_o = idx_q[1];
  always_ff @(posedge clk_i)
  begin
    if (clr_i) overlap_o <= 0;
    else if ((pins_i[5] & pins_i[4]) | (pins_i[3] & pins_i[2]) | (pins_i[1] & pins_i[0]))
      overlap_o <= overlap_o + 1;
  end
endmodule

// >>> bench/motor_pwm_and_quadrature_timer_test.sv
`timescale 1ns/1ps
module motor_pwm_and_quadrature_timer_test;
  import mpq_pkg::*;
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [5:0]  addr_i = 6'h00;
  logic [15:0] wdata_i = 16'h0000, rdata_o, v, mx;
  logic        step = 1'b0, dir = 1'b0, wob = 1'b0, clr = 1'b1, pa, pb, sync_o, en_o, dn;
  logic [5:0]  pins;
  int          err_count = 0, tests_run = 0, ovl, tg[4], hi[4];
  always #5 clk_i = ~clk_i;
  mpq_timer i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .enc_phase_a_ch1_i(pa),
    .enc_phase_b_ch1_i(pb), .ch3_pin_a_sync_toggle_o(sync_o), .pwm_phase1_pos_o(pins[5]),
    .pwm_phase1_neg_o(pins[4]), .pwm_phase2_pos_o(pins[3]), .pwm_phase2_neg_o(pins[2]),
    .pwm_phase3_pos_o(pins[1]), .pwm_phase3_neg_o(pins[0]), .pwm_pins_en_o(en_o));
  mpq_motor_model i_model (.clk_i(clk_i), .step_i(step), .dir_i(dir), .wob_i(wob),
    .clr_i(clr), .pins_i(pins), .phase_a_o(pa), .phase_b_o(pb), .overlap_o(ovl));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic c);
    check({15'h0000, c}, 16'h0001);
  endtask
  task automatic chk_en(input logic e);
    @(negedge clk_i);
    chk1(en_o === e);
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [5:0] a);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [15:0] e);
    rd(a);
    check(v, e);
  endtask
  task automatic enc(input logic d, input logic w);
    step <= ~w;
    wob <= w;
    dir <= d;
    @(posedge clk_i);
    step <= 1'b0;
    wob <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic meas(input int n);
    logic [3:0] prv, cur;
    tg = '{0, 0, 0, 0};
    hi = '{0, 0, 0, 0};
    prv = {sync_o, pins[1], pins[3], pins[5]};
    repeat (n)
    begin
      @(posedge clk_i);
      #1 cur = {sync_o, pins[1], pins[3], pins[5]};
      for (int k = 0; k < 4; k++)
      begin
        tg[k] += int'(cur[k] != prv[k]);
        hi[k] += int'(cur[k]);
      end
      prv = cur;
    end
    @(posedge clk_i);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    print_verdict();
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    clr <= 1'b0;
    @(posedge clk_i);
    rdc(ADR_BUS_CTRL, 16'h2000);
    wr(ADR_PERIOD, 16'h0123);
    wr(ADR_PH1_BUF, 16'h0055);
    wr(ADR_BUS_CTRL, 16'h0000);
    wr(ADR_PERIOD, 16'h0777);
    rdc(ADR_PERIOD, 16'h0000);
    rdc(ADR_PH1_BUF, 16'h0055);
    wr(ADR_BUS_CTRL, 16'h2000);
    rdc(ADR_PERIOD, 16'h0123);
    wr(ADR_SUBCNT, 16'h1234);
    rd(ADR_SUBCNT);
    chk1(v !== 16'h1234);
    wr(6'h3f, 16'h00ff);
    rdc(6'h3f, 16'h0000);
    wr(ADR_CH1_MODE, {12'h000, MODE_PHASE4});
    wr(ADR_CH1_CNT, 16'h0000);
    wr(ADR_CH0_SPD, 16'h0010);
    wr(ADR_CH0_POS, 16'h0020);
    wr(ADR_CH0_CNT, 16'h0000);
    wr(ADR_CH0_CTRL, 16'h0001);
    wr(ADR_RUN, 16'h0003);
    for (int i = 0; i < 8; i++) enc(1'b1, 1'b0);
    rdc(ADR_CH1_CNT, 16'h0004);
    rdc(ADR_CH0_CAP, 16'h0012);
    enc(1'b0, 1'b1);
    enc(1'b0, 1'b1);
    rdc(ADR_CH1_CNT, 16'h0004);
    for (int i = 0; i < 4; i++) enc(1'b0, 1'b0);
    rdc(ADR_CH1_CNT, 16'h0002);
    repeat (80) @(posedge clk_i);
    rdc(ADR_CH1_CAPA, 16'h0002);
    rdc(ADR_CH1_CAPB, 16'h0002);
    wr(ADR_RUN, 16'h0000);
    wr(ADR_CH3_CTRL, {8'h00, CLR_PERIOD, 5'h00});
    wr(ADR_CH3_CNT, 16'h0000);
    wr(ADR_CH4_CNT, 16'h0000);
    wr(ADR_PERIOD, 16'h0009);
    wr(ADR_PH1_CMP, 16'h0003);
    wr(ADR_PH2_CMP, 16'h0006);
    wr(ADR_PH3_CMP, 16'h0009);
    wr(ADR_OUT_CTRL, 16'h0043);
    wr(ADR_CH3_MODE, {12'h000, MODE_RSYNC});
    chk_en(1'b1);
    wr(ADR_RUN, 16'h00c0);
    meas(200);
    check(16'(tg[0]), 16'h0028);
    check(16'(tg[1]), 16'h0028);
    check(16'(tg[2]), 16'h0014);
    check(16'(tg[3]), 16'h0014);
    chk1(hi[0] == 80 || hi[0] == 120);
    chk1(hi[1] == 60 || hi[1] == 140);
    rd(ADR_CH3_CNT);
    chk1(v <= 16'h0009);
    wr(ADR_RUN, 16'h0000);
    rd(ADR_CH3_CNT);
    mx = v;
    meas(50);
    check(16'(tg[0] + tg[1] + tg[2] + tg[3]), 16'h0000);
    rdc(ADR_CH3_CNT, mx);
    wr(ADR_CH3_MODE, {12'h000, MODE_NORMAL});
    chk_en(1'b0);
    wr(ADR_DEADTIME, 16'h0002);
    wr(ADR_CYC_BUF, 16'h0008);
    wr(ADR_CYC_DATA, 16'h0008);
    wr(ADR_PER_BUF, 16'h000a);
    wr(ADR_PERIOD, 16'h000a);
    wr(ADR_PH1_BUF, 16'h0004);
    wr(ADR_PH2_BUF, 16'h0004);
    wr(ADR_PH3_BUF, 16'h0004);
    wr(ADR_CH4_CNT, 16'h0000);
    wr(ADR_CH3_CTRL, 16'h0001);
    // ch3 pin c stays a plain port
    wr(ADR_CH3_MODE, {12'h000, MODE_COMP_LO});
    chk_en(1'b1);
    clr <= 1'b1;
    wr(ADR_RUN, 16'h00c0);
    clr <= 1'b0;
    mx = 16'h0000;
    dn = 1'b0;
    for (int i = 0; i < 30; i++)
    begin
      rd(ADR_CH4_CNT);
      if (v < mx) dn = 1'b1;
      mx = v;
      chk1(v <= 16'h0008);
    end
    chk1(dn);
    check(16'(ovl), 16'h0000);
    print_verdict();
  end
endmodule
bind mpq_timer mpq_timer_monitor i_mon (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .ch3_pin_a_sync_toggle_o(ch3_pin_a_sync_toggle_o), .pwm_phase1_pos_o(pwm_phase1_pos_o),
  .pwm_phase1_neg_o(pwm_phase1_neg_o), .pwm_phase2_pos_o(pwm_phase2_pos_o),
  .pwm_phase2_neg_o(pwm_phase2_neg_o), .pwm_phase3_pos_o(pwm_phase3_pos_o),
  .pwm_phase3_neg_o(pwm_phase3_neg_o), .pwm_pins_en_o(pwm_pins_en_o));
